// ===== src/smcg_params.svh
// Purpose: shared constants of the sleep mode clock gating block
// Assumes: 250 MHz system clock
// Notes: mode codes are the values presented on the sleep mode port
`ifndef SMCG_PARAMS_SVH
`define SMCG_PARAMS_SVH

`define SMCG_MODE_IDLE 3'h0
`define SMCG_MODE_PDOWN 3'h1
`define SMCG_MODE_PSAVE 3'h2
`define SMCG_MODE_STANDBY 3'h3
`define SMCG_MODE_EXTSTBY 3'h4

`define SMCG_RC_STARTUP_CYC 14'h0006
`define SMCG_ISR_MIN_CYC 14'h000D
`define SMCG_XTAL_STARTUP_CYC 14'h03E8
`define SMCG_CNT_W 14
`define SMCG_SYNC_N 4
`define SMCG_PRB_W 8

`endif

// ===== src/smcg_pkg.sv
// Purpose: types of the sleep mode clock gating block
// Assumes: nothing
// Notes: domain vector order is {per, rtc, sys_osc, rtc_osc, dma}
package smcg_pkg;
  typedef enum logic [2:0] {
    SMCG_ACTIVE,
    SMCG_SLEEP,
    SMCG_OSC_WAIT,
    SMCG_STARTUP,
    SMCG_ISR_WAIT
  } smcg_state_e;

  typedef logic [4:0] smcg_dom_t;
endpackage : smcg_pkg

// ===== src/smcg_sync.sv
// Purpose: three-stage synchroniser for one asynchronous level
// Assumes: input may change at any time
// Notes: output follows only when stages two and three agree
`timescale 1ns/10ps
module smcg_sync (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic out;
  } smcg_sync_s;

  smcg_sync_s st_reg;
  smcg_sync_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // two-stage agreement filters a single metastable sample
    if (st_reg.s2 == st_reg.s3) begin
      st_next.out = st_reg.s3;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.out;
endmodule : smcg_sync

// ===== src/smcg_ctrl.sv
// Purpose: sleep mode controller gating cpu, peripheral and rtc clocks and oscillators
// Assumes: sleep request and peripheral interrupt come from logic on sys_clk_in
// Notes: pin wake sources, rtc interrupt and oscillator ready pass synchronisers
// Behaviour
// [RQ1] cpu clock stops in every sleep mode; mode chosen per entry
// [RQ2] idle stops only cpu and nonvolatile memories; other clocks run
// [RQ3] idle keeps dma and event routing running
// [RQ4] idle wakes on any enabled interrupt
// [RQ5] power-save keeps rtc clock and oscillator; stops rest; rtc wakes
// [RQ6] power-save wake waits for restarted system oscillator to stabilise
// [RQ7] power-down stops everything; no internal timer wakes it
// [RQ8] outside party wakes power-down via pin interrupt or address match
// [RQ9] battery backup variant keeps rtc running in every sleep mode
// [RQ10] standby is power-down with system oscillator kept running
// [RQ11] extended standby is power-save with system oscillator kept running
// [RQ12] port and address-match interrupts wake every sleep mode
// [RQ13] deep non-standby wake adds six cycles with rc or external clock
// [RQ14] power-save and power-down stop peripherals regardless of reduction bits
// [RQ15] at least thirteen cycles pass after wake before isr starts
// [RQ16] wake restarts gated domains, applies delay, then releases cpu clock
`timescale 1ns/10ps
`include "smcg_params.svh"
module smcg_ctrl #(
  parameter int PRB_W = `SMCG_PRB_W,
  parameter bit BATT_RTC = 1'b0,
  parameter logic [`SMCG_CNT_W-1:0] XTAL_STARTUP_CYC = `SMCG_XTAL_STARTUP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sleep_req_in,
  input wire logic [2:0] sleep_mode_in,
  input wire logic periph_irq_in,
  input wire logic async_port_irq_in,
  input wire logic two_wire_port_match_in,
  input wire logic rtc_irq_in,
  input wire logic sys_osc_ready_in,
  input wire logic rc_clock_sel_in,
  input wire logic [PRB_W-1:0] power_reduction_bits_in,
  output logic cpu_clk_en_out,
  output logic nvm_en_out,
  output logic periph_clk_en_out,
  output logic rtc_clk_en_out,
  output logic sys_osc_en_out,
  output logic rtc_osc_en_out,
  output logic dma_event_en_out,
  output logic [PRB_W-1:0] module_clk_en_out,
  output logic sleeping_out,
  output logic wake_pulse_out,
  output logic isr_allow_out
);
  typedef struct packed {
    smcg_pkg::smcg_state_e state;
    logic [2:0] mode;
    logic [`SMCG_CNT_W-1:0] cnt;
    logic cpu_en;
    logic nvm_en;
    smcg_pkg::smcg_dom_t dom;
    logic [PRB_W-1:0] mod_en;
    logic wake;
    logic isr_ok;
  } smcg_ctrl_s;

  smcg_ctrl_s st_reg;
  smcg_ctrl_s st_next;
  logic [`SMCG_SYNC_N-1:0] raw_async;
  logic [`SMCG_SYNC_N-1:0] sync_async;
  logic port_s;
  logic match_s;
  smcg_pkg::smcg_dom_t entry_dom;
  smcg_pkg::smcg_dom_t cur_dom;
  logic rtc_s;
  logic osc_s;
  logic mode_ok;
  logic wake_src;
  logic deep_mode;

  assign raw_async = {sys_osc_ready_in, rtc_irq_in, two_wire_port_match_in, async_port_irq_in};

  generate
    for (genvar i = 0; i < `SMCG_SYNC_N; i++) begin : g_sync
      smcg_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(raw_async[i]),
        .sync_out(sync_async[i])
      );
    end
  endgenerate

  assign port_s = sync_async[0];
  assign match_s = sync_async[1];
  assign rtc_s = sync_async[2];
  assign osc_s = sync_async[3];

  // domains kept alive per mode, order {per, rtc, sys_osc, rtc_osc, dma}
  function automatic smcg_pkg::smcg_dom_t sleep_domains(input logic [2:0] m);
    smcg_pkg::smcg_dom_t d;
    d = 5'h00;
    case (m)
      // [RQ2] [RQ3] idle keeps all clocks
      `SMCG_MODE_IDLE: d = 5'h1F;
      // [RQ7] power-down all off
      `SMCG_MODE_PDOWN: d = 5'h00;
      // [RQ5] power-save rtc only
      `SMCG_MODE_PSAVE: d = 5'h0A;
      // [RQ10] standby sys osc only
      `SMCG_MODE_STANDBY: d = 5'h04;
      // [RQ11] extended standby rtc plus osc
      `SMCG_MODE_EXTSTBY: d = 5'h0E;
      default: d = 5'h1F;
    endcase
    // [RQ9] backed-up rtc never stops
    if (BATT_RTC) begin
      d = d | 5'h0A;
    end
    return d;
  endfunction : sleep_domains

  assign mode_ok = (sleep_mode_in <= `SMCG_MODE_EXTSTBY);
  assign deep_mode = (st_reg.mode == `SMCG_MODE_PDOWN) || (st_reg.mode == `SMCG_MODE_PSAVE);
  // domain vectors held as nets so single bits can be selected
  assign entry_dom = sleep_domains(sleep_mode_in);
  assign cur_dom = sleep_domains(st_reg.mode);

  // wake qualification per mode
  always_comb begin
    // [RQ12] pin and address-match wake always
    wake_src = port_s | match_s;
    case (st_reg.mode)
      // [RQ4] idle any interrupt
      `SMCG_MODE_IDLE: wake_src = wake_src | periph_irq_in | rtc_s;
      // [RQ5] [RQ11] rtc wake allowed
      `SMCG_MODE_PSAVE, `SMCG_MODE_EXTSTBY: wake_src = wake_src | rtc_s;
      // [RQ7] [RQ10] no timer wake; relies on outside stimulus
      default: wake_src = port_s | match_s;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.wake = 1'b0;
    case (st_reg.state)
      smcg_pkg::SMCG_ACTIVE: begin
        st_next.mod_en = ~power_reduction_bits_in;
        // [RQ1] stop cpu, mode taken fresh each entry
        if (sleep_req_in && mode_ok) begin
          st_next.state = smcg_pkg::SMCG_SLEEP;
          st_next.mode = sleep_mode_in;
          st_next.cpu_en = 1'b0;
          st_next.nvm_en = 1'b0;
          st_next.dom = entry_dom;
          // [RQ14] peripheral clock off overrides reduction bits
          if (entry_dom[4] == 1'b0) begin
            st_next.mod_en = '0;
          end
        end
      end
      smcg_pkg::SMCG_SLEEP: begin
        if (cur_dom[4]) begin
          st_next.mod_en = ~power_reduction_bits_in;
        end
        // [RQ16] restart gated domains on wake
        if (wake_src) begin
          st_next.dom = 5'h1F;
          st_next.mod_en = ~power_reduction_bits_in;
          st_next.cnt = '0;
          if (deep_mode) begin
            st_next.state = smcg_pkg::SMCG_OSC_WAIT;
          end else begin
            st_next.state = smcg_pkg::SMCG_STARTUP;
          end
        end
      end
      smcg_pkg::SMCG_OSC_WAIT: begin
        st_next.mod_en = ~power_reduction_bits_in;
        // [RQ6] hold until oscillator ready
        if (osc_s) begin
          st_next.state = smcg_pkg::SMCG_STARTUP;
          // [RQ13] six cycle start-up for rc or external clock
          if (rc_clock_sel_in) begin
            st_next.cnt = `SMCG_RC_STARTUP_CYC - 14'h0001;
          end else begin
            st_next.cnt = XTAL_STARTUP_CYC - 14'h0001;
          end
        end
      end
      smcg_pkg::SMCG_STARTUP: begin
        st_next.mod_en = ~power_reduction_bits_in;
        if (st_reg.cnt == '0) begin
          // [RQ16] release cpu clock last
          st_next.state = smcg_pkg::SMCG_ISR_WAIT;
          st_next.cpu_en = 1'b1;
          st_next.nvm_en = 1'b1;
          st_next.wake = 1'b1;
          st_next.isr_ok = 1'b0;
          st_next.cnt = `SMCG_ISR_MIN_CYC - 14'h0001;
        end else begin
          st_next.cnt = st_reg.cnt - 14'h0001;
        end
      end
      smcg_pkg::SMCG_ISR_WAIT: begin
        st_next.mod_en = ~power_reduction_bits_in;
        // [RQ15] vector stacking window
        if (st_reg.cnt == '0) begin
          st_next.state = smcg_pkg::SMCG_ACTIVE;
          st_next.isr_ok = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt - 14'h0001;
        end
      end
      default: begin
        st_next.state = smcg_pkg::SMCG_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg.state <= smcg_pkg::SMCG_ACTIVE;
      st_reg.mode <= `SMCG_MODE_IDLE;
      st_reg.cnt <= '0;
      st_reg.cpu_en <= 1'b1;
      st_reg.nvm_en <= 1'b1;
      st_reg.dom <= 5'h1F;
      st_reg.mod_en <= '1;
      st_reg.wake <= 1'b0;
      st_reg.isr_ok <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_clk_en_out = st_reg.cpu_en;
  assign nvm_en_out = st_reg.nvm_en;
  assign periph_clk_en_out = st_reg.dom[4];
  assign rtc_clk_en_out = st_reg.dom[3];
  assign sys_osc_en_out = st_reg.dom[2];
  assign rtc_osc_en_out = st_reg.dom[1];
  assign dma_event_en_out = st_reg.dom[0];
  assign module_clk_en_out = st_reg.mod_en;
  assign sleeping_out = (st_reg.state == smcg_pkg::SMCG_SLEEP);
  assign wake_pulse_out = st_reg.wake;
  assign isr_allow_out = st_reg.isr_ok;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_cpu_sleep_stop: assert property ( // [RQ1]
    sleeping_out |-> !cpu_clk_en_out && !nvm_en_out)
    else $error("cpu clock running in sleep");

  chk_idle_clocks_run: assert property ( // [RQ2]
    sleeping_out && st_reg.mode == `SMCG_MODE_IDLE |->
      periph_clk_en_out && rtc_clk_en_out && sys_osc_en_out && rtc_osc_en_out)
    else $error("idle stopped a clock domain");

  chk_idle_dma_on: assert property ( // [RQ3]
    sleeping_out && st_reg.mode == `SMCG_MODE_IDLE |-> dma_event_en_out)
    else $error("idle stopped dma and events");

  chk_idle_any_wake: assert property ( // [RQ4]
    sleeping_out && st_reg.mode == `SMCG_MODE_IDLE && periph_irq_in |=> !sleeping_out)
    else $error("idle ignored interrupt");

  chk_psave_gating: assert property ( // [RQ5]
    sleeping_out && st_reg.mode == `SMCG_MODE_PSAVE |->
      rtc_clk_en_out && rtc_osc_en_out && !periph_clk_en_out && !sys_osc_en_out)
    else $error("power-save gating wrong");

  chk_osc_hold_cpu: assert property ( // [RQ6]
    st_reg.state == smcg_pkg::SMCG_OSC_WAIT && !osc_s |=> !cpu_clk_en_out)
    else $error("cpu released before oscillator ready");

  chk_pdown_no_timer: assert property ( // [RQ7]
    sleeping_out && st_reg.mode == `SMCG_MODE_PDOWN && !port_s && !match_s |=> sleeping_out)
    else $error("power-down woke without external stimulus");

  chk_batt_rtc_run: assert property ( // [RQ9]
    BATT_RTC |-> rtc_clk_en_out && rtc_osc_en_out)
    else $error("backed-up rtc stopped");

  chk_standby_osc: assert property ( // [RQ10]
    sleeping_out && st_reg.mode == `SMCG_MODE_STANDBY |-> sys_osc_en_out && !periph_clk_en_out)
    else $error("standby gating wrong");

  chk_extstby_osc: assert property ( // [RQ11]
    sleeping_out && st_reg.mode == `SMCG_MODE_EXTSTBY |-> sys_osc_en_out && rtc_clk_en_out)
    else $error("extended standby gating wrong");

  chk_async_wake_all: assert property ( // [RQ12]
    sleeping_out && (port_s || match_s) |=> !sleeping_out)
    else $error("pin wake ignored");

  chk_rc_startup_six: assert property ( // [RQ13]
    st_reg.state == smcg_pkg::SMCG_OSC_WAIT && osc_s && rc_clock_sel_in |=>
      !cpu_clk_en_out [*6] ##1 cpu_clk_en_out)
    else $error("rc start-up delay not six cycles");

  chk_prb_override: assert property ( // [RQ14]
    sleeping_out && (st_reg.mode == `SMCG_MODE_PSAVE || st_reg.mode == `SMCG_MODE_PDOWN)
      |-> module_clk_en_out == '0)
    else $error("peripheral module clocked in deep sleep");

  chk_isr_thirteen: assert property ( // [RQ15]
    $rose(cpu_clk_en_out) |-> !isr_allow_out [*8] ##1 !isr_allow_out [*5] ##1 isr_allow_out)
    else $error("isr window not thirteen cycles");

  chk_release_order: assert property ( // [RQ16]
    wake_pulse_out |-> cpu_clk_en_out && periph_clk_en_out && sys_osc_en_out &&
      !$past(cpu_clk_en_out))
    else $error("cpu released before domains restarted");
endmodule : smcg_ctrl

// ===== bench/smcg_partner.sv
// Purpose: system oscillator model beside the sleep controller
// Assumes: enable comes from the controller on sys_clk_in
// Notes: ready drops at once when stopped, so a stale high never hides a restart
`timescale 1ns/10ps
module smcg_partner #(
  parameter int OSC_DLY = 5
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic sys_osc_en_in,
  output logic sys_osc_ready_out
);
  int cnt;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= OSC_DLY;
    end else if (!sys_osc_en_in) begin
      cnt <= 0;
    end else if (cnt < OSC_DLY) begin
      cnt <= cnt + 1;
    end
  end
  assign sys_osc_ready_out = sys_osc_en_in && (cnt >= OSC_DLY);
endmodule : smcg_partner

// ===== bench/tb_top.sv
// Purpose: self-checking bench of the sleep mode controller
// Assumes: xtal start-up shortened to 20 cycles
// Notes: outputs sampled on the falling edge
`timescale 1ns/10ps
`include "smcg_params.svh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, gt); end end
module tb_top;
  localparam int XTAL = 20;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic sleep_req = 1'b0;
  logic [2:0] sleep_mode = 3'h0;
  logic periph_irq = 1'b0;
  logic port_irq = 1'b0;
  logic match_irq = 1'b0;
  logic rtc_irq = 1'b0;
  logic rc_sel = 1'b1;
  logic [7:0] prb = 8'h5A;
  logic osc_ready;
  logic cpu_en, nvm_en, per_en, rtc_en, osc_en, rosc_en, dma_en;
  logic [7:0] mod_en;
  logic sleeping, wake_p, isr_ok;
  int n_mismatch = 0;
  int samples_checked = 0;
  int g1, g2;
  always #2 sys_clk_in = ~sys_clk_in;
  smcg_ctrl #(.XTAL_STARTUP_CYC(XTAL)) dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .sleep_req_in(sleep_req), .sleep_mode_in(sleep_mode), .periph_irq_in(periph_irq),
    .async_port_irq_in(port_irq), .two_wire_port_match_in(match_irq), .rtc_irq_in(rtc_irq),
    .sys_osc_ready_in(osc_ready), .rc_clock_sel_in(rc_sel), .power_reduction_bits_in(prb),
    .cpu_clk_en_out(cpu_en), .nvm_en_out(nvm_en), .periph_clk_en_out(per_en),
    .rtc_clk_en_out(rtc_en), .sys_osc_en_out(osc_en), .rtc_osc_en_out(rosc_en),
    .dma_event_en_out(dma_en), .module_clk_en_out(mod_en), .sleeping_out(sleeping),
    .wake_pulse_out(wake_p), .isr_allow_out(isr_ok));
  smcg_partner osc (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .sys_osc_en_in(osc_en),
    .sys_osc_ready_out(osc_ready));
  // domains kept per mode: {per, rtc, sys_osc, rtc_osc, dma}
  function automatic logic [4:0] exp_dom(input logic [2:0] m);
    case (m)
      `SMCG_MODE_IDLE: exp_dom = 5'h1F;
      `SMCG_MODE_PSAVE: exp_dom = 5'h0A;
      `SMCG_MODE_STANDBY: exp_dom = 5'h04;
      `SMCG_MODE_EXTSTBY: exp_dom = 5'h0E;
      default: exp_dom = 5'h00;
    endcase
  endfunction : exp_dom
  task go_sleep(input logic [2:0] m);
    @(posedge sys_clk_in);
    sleep_req <= 1'b1;
    sleep_mode <= m;
    @(posedge sys_clk_in);
    sleep_req <= 1'b0;
    @(negedge sys_clk_in);
  endtask : go_sleep
  // gap: cycles from leaving sleep to cpu release
  task wake(output int gap);
    int n;
    n = 0;
    while (sleeping !== 1'b0 && n < 200) begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK("sleep_left", 1'b0, sleeping)
    `CHK("per_on", 1'b1, per_en)
    gap = 0;
    while (cpu_en !== 1'b1 && gap < 200) begin
      @(negedge sys_clk_in);
      gap++;
    end
    `CHK("cpu_on", 1'b1, cpu_en)
    `CHK("wake_pulse", 1'b1, wake_p)
    `CHK("nvm_en", 1'b1, nvm_en)
    n = 0;
    while (isr_ok !== 1'b1 && n < 50) begin
      @(negedge sys_clk_in);
      n++;
    end
    `CHK("isr_low", 13, n)
  endtask : wake
  task clear_src;
    @(posedge sys_clk_in);
    {port_irq, match_irq, rtc_irq, periph_irq} <= 4'h0;
    repeat (6) @(posedge sys_clk_in);
  endtask : clear_src
  task t_reset;
    @(negedge sys_clk_in);
    `CHK("rst_cpu", 1'b1, cpu_en)
    `CHK("rst_sleep", 1'b0, sleeping)
    `CHK("rst_mod", 8'hFF, mod_en)
    $display("test reset done");
  endtask : t_reset
  task t_modes;
    int g;
    for (int m = 0; m < 5; m++) begin
      go_sleep(m[2:0]);
      `CHK("cpu_off", 1'b0, cpu_en)
      `CHK("domains", exp_dom(m[2:0]), {per_en, rtc_en, osc_en, rosc_en, dma_en})
      if (m < 3) `CHK("mod_en", (m == 0) ? ~prb : 8'h00, mod_en)
      @(posedge sys_clk_in);
      if (m[0]) match_irq <= 1'b1;
      else port_irq <= 1'b1;
      wake(g);
      if (m == 1 || m == 2) `CHK("deep_gap", 1'b1, g >= 7)
      else `CHK("fast_gap", 1, g)
      clear_src();
    end
    $display("test modes done");
  endtask : t_modes
  task t_refuse;
    int g;
    go_sleep(3'h5);
    `CHK("bad_mode", 1'b0, sleeping)
    go_sleep(`SMCG_MODE_PDOWN);
    @(posedge sys_clk_in);
    rtc_irq <= 1'b1;
    periph_irq <= 1'b1;
    repeat (20) @(negedge sys_clk_in);
    `CHK("pdown_hold", 1'b1, sleeping)
    @(posedge sys_clk_in);
    port_irq <= 1'b1;
    wake(g);
    clear_src();
    go_sleep(`SMCG_MODE_PSAVE);
    @(posedge sys_clk_in);
    rtc_irq <= 1'b1;
    wake(g);
    `CHK("rtc_wake", 1'b1, g >= 7)
    clear_src();
    go_sleep(`SMCG_MODE_IDLE);
    @(posedge sys_clk_in);
    periph_irq <= 1'b1;
    wake(g);
    `CHK("idle_wake", 1, g)
    clear_src();
    $display("test refuse done");
  endtask : t_refuse
  task t_startup;
    go_sleep(`SMCG_MODE_PDOWN);
    @(posedge sys_clk_in);
    port_irq <= 1'b1;
    wake(g1);
    clear_src();
    rc_sel <= 1'b0;
    go_sleep(`SMCG_MODE_PDOWN);
    @(posedge sys_clk_in);
    port_irq <= 1'b1;
    wake(g2);
    clear_src();
    `CHK("xtal_minus_rc", XTAL - 6, g2 - g1)
    $display("test startup done");
  endtask : t_startup
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    t_reset();
    repeat (6) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_modes();
    t_refuse();
    t_startup();
    give_verdict();
  end
endmodule : tb_top
